// ---- ddr_strobe_consts.vh ----
// constants for the ddr strobe read/write alignment block
// assumes inclusion by bare name from the design files
`ifndef DDR_STROBE_CONSTS_VH
`define DDR_STROBE_CONSTS_VH
// ------------------------------------------------------------
// group layout
// ------------------------------------------------------------
`define CELLS_GROUP_A 14
`define CELLS_GROUP_B 12
`define NUM_GROUPS 2
`define DQ_MAX_W 16
// ------------------------------------------------------------
// calibration and delay line
// ------------------------------------------------------------
`define CAL_CODE_W 6
`define CAL_CODE_RST 6'h00
`define DELAY_TAPS 64
// ------------------------------------------------------------
// read sequencer states, burst length and fifo depth
// ------------------------------------------------------------
`define ST_IDLE 3'h0
`define ST_WAIT_PRE 3'h1
`define ST_WAIT_RISE 3'h2
`define ST_CAPTURE 3'h3
`define ST_DRAIN 3'h4
`define BURST_W 8
`define BURST_DEF 8'h08
`define FIFO_DEPTH 8
`endif

// ---- strobe_fifo.v ----
// small fifo carrying captured read words into the system clock domain
// assumes one clock, synchronous active-high reset
module strobe_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire srst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output reg [WIDTH-1:0] out_data_ff,
    output reg out_valid_ff,
    input wire out_ready,
    output wire empty
);
    // ------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // entry storage
    reg [AW-1:0] wptr_ff; // write pointer
    reg [AW-1:0] rptr_ff; // read pointer
    reg [AW:0] cnt_ff; // entries held in memory
    wire push; // write accepted
    wire pop; // memory to output register
    wire [AW:0] depth_c; // depth at counter width
    assign depth_c = DEPTH[AW:0];
    assign in_ready = (cnt_ff != depth_c);
    assign push = in_valid && in_ready;
    assign pop = (cnt_ff != {(AW+1){1'b0}}) && (!out_valid_ff || out_ready);
    assign empty = (cnt_ff == {(AW+1){1'b0}}) && !out_valid_ff;
    // write side
    always @(posedge clk) begin
        if (push) begin
            mem[wptr_ff] <= in_data;
        end
    end
    // pointers, count and registered output
    always @(posedge clk) begin
        if (srst) begin
            wptr_ff <= {AW{1'b0}};
            rptr_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
            out_valid_ff <= 1'b0;
            out_data_ff <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wptr_ff <= (wptr_ff == depth_c[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_ff + 1'b1;
            end
            if (pop) begin
                rptr_ff <= (rptr_ff == depth_c[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_ff + 1'b1;
                out_data_ff <= mem[rptr_ff];
                out_valid_ff <= 1'b1;
            end else if (out_ready) begin
                out_valid_ff <= 1'b0; // consumed, nothing behind it
            end
            cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // strobe_fifo

// ---- ddr_strobe_read_write_align.v ----
// strobe read/write alignment for one edge cell group of a ddr interface
// assumes dqs and dq arrive as pins, asynchronous to clk; pvt code from outside
`include "ddr_strobe_consts.vh"
module ddr_strobe_read_write_align #(
    parameter GROUP_CELLS = `CELLS_GROUP_A,
    parameter DQ_W = 8, // data cells in this group
    parameter FIFO_DEPTH = `FIFO_DEPTH,
    parameter FIFO_AW = 3
) (
    input wire clk,
    input wire srst,
    input wire read_start, // one-cycle request for a read burst
    input wire [`BURST_W-1:0] burst_words, // words expected per burst
    input wire [`CAL_CODE_W-1:0] pvt_code, // pvt target for the dll
    input wire dqs_pin, // strobe from memory
    input wire [DQ_W-1:0] dq_pin, // read data from memory
    input wire wr_load, // write word pair present
    input wire [DQ_W-1:0] wr_d0,
    input wire [DQ_W-1:0] wr_d1,
    input wire rd_ready,
    output reg read_strobe_shifted_ff,
    output reg write_strobe_shifted_ff,
    output reg capture_polarity_select_ff,
    output reg read_data_valid_flag_ff,
    output reg dll_locked_ff,
    output reg overflow_ff,
    output reg [DQ_W-1:0] dq_out_ff,
    output reg dq_oe_ff,
    output wire [DQ_W-1:0] rd_data_ff,
    output wire rd_valid_ff
);
    // ------------------------------------------------------------
    // width limits
    // ------------------------------------------------------------
    localparam TOTAL_W = DQ_W * `NUM_GROUPS;
    localparam GROUP_OK = (GROUP_CELLS == `CELLS_GROUP_A) || (GROUP_CELLS == `CELLS_GROUP_B);
    localparam W_OK = (TOTAL_W <= `DQ_MAX_W) && GROUP_OK;
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg dqs_s1_ff; // first stage, read only by second
    reg dqs_s2_ff;
    reg [DQ_W-1:0] dq_s1_ff;
    reg [DQ_W-1:0] dq_s2_ff;
    always @(posedge clk) begin
        dqs_s1_ff <= dqs_pin;
        dqs_s2_ff <= dqs_s1_ff;
        dq_s1_ff <= dq_pin;
        dq_s2_ff <= dq_s1_ff;
    end
    // ------------------------------------------------------------
    // dll: code tracks pvt, loop closed on clk
    // ------------------------------------------------------------
    reg [`CAL_CODE_W-1:0] cal_code_ff; // calibration code
    // one step per clock toward the target, lock when matched
    always @(posedge clk) begin
        if (srst) begin
            cal_code_ff <= `CAL_CODE_RST;
            dll_locked_ff <= 1'b0;
        end else begin
            if (cal_code_ff < pvt_code) begin
                cal_code_ff <= cal_code_ff + 1'b1;
            end else if (cal_code_ff > pvt_code) begin
                cal_code_ff <= cal_code_ff - 1'b1;
            end
            dll_locked_ff <= (cal_code_ff == pvt_code);
        end
    end
    // ------------------------------------------------------------
    // dqs delay line and strobes
    // ------------------------------------------------------------
    reg [`DELAY_TAPS-1:0] dqs_line_ff; // sampled dqs history
    reg rs_prev_ff; // previous read strobe, edge finding
    wire [`CAL_CODE_W-1:0] wr_tap; // write strobe tap, half the read delay
    assign wr_tap = {1'b0, cal_code_ff[`CAL_CODE_W-1:1]};
    always @(posedge clk) begin
        if (srst) begin
            dqs_line_ff <= {`DELAY_TAPS{1'b0}};
            read_strobe_shifted_ff <= 1'b0;
            write_strobe_shifted_ff <= 1'b0;
            rs_prev_ff <= 1'b0;
        end else begin
            dqs_line_ff <= {dqs_line_ff[`DELAY_TAPS-2:0], dqs_s2_ff};
            read_strobe_shifted_ff <= dqs_line_ff[cal_code_ff];
            write_strobe_shifted_ff <= dqs_line_ff[wr_tap];
            rs_prev_ff <= read_strobe_shifted_ff;
        end
    end
    wire rs_rise; // delayed strobe rising
    wire rs_fall; // delayed strobe falling
    assign rs_rise = read_strobe_shifted_ff && !rs_prev_ff;
    assign rs_fall = !read_strobe_shifted_ff && rs_prev_ff;
    // ------------------------------------------------------------
    // system clock phase reference for polarity choice
    // ------------------------------------------------------------
    reg phase_ff; // toggles every clock
    always @(posedge clk) begin
        if (srst) begin
            phase_ff <= 1'b0;
        end else begin
            phase_ff <= !phase_ff;
        end
    end
    // ------------------------------------------------------------
    // read sequencer
    // ------------------------------------------------------------
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [`BURST_W-1:0] words_ff; // words captured this burst
    reg [`BURST_W-1:0] target_ff; // burst length latched at start
    wire fifo_in_ready;
    wire fifo_empty;
    wire cap_edge; // capture on either strobe edge in the clock phase the polarity names
    assign cap_edge = (capture_polarity_select_ff == phase_ff) ? (rs_rise || rs_fall) : 1'b0;
    wire cap_any; // both strobe edges carry a word
    assign cap_any = rs_rise || rs_fall;
    wire first_rise; // first delayed rise after the preamble carries word one
    assign first_rise = (state_ff == `ST_WAIT_RISE) && rs_rise;
    wire push; // word enters fifo
    assign push = (((state_ff == `ST_CAPTURE) && cap_any) || first_rise) && W_OK;
    // next state
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            `ST_IDLE: begin
                if (read_start) begin
                    nxt_state = `ST_WAIT_PRE;
                end
            end
            `ST_WAIT_PRE: begin
                if (!dqs_s2_ff) begin
                    nxt_state = `ST_WAIT_RISE;
                end
            end
            `ST_WAIT_RISE: begin
                if (push && (words_ff + 1'b1 == target_ff)) begin
                    nxt_state = `ST_DRAIN; // single word burst ends at its first rise
                end else if (rs_rise) begin
                    nxt_state = `ST_CAPTURE;
                end
            end
            `ST_CAPTURE: begin
                if (push && (words_ff + 1'b1 == target_ff)) begin
                    nxt_state = `ST_DRAIN;
                end
            end
            `ST_DRAIN: begin
                if (fifo_empty) begin
                    nxt_state = `ST_IDLE;
                end
            end
            default: begin
                nxt_state = `ST_IDLE;
            end
        endcase
    end
    // state, counters, polarity, valid
    always @(posedge clk) begin
        if (srst) begin
            state_ff <= `ST_IDLE;
            words_ff <= {`BURST_W{1'b0}};
            target_ff <= `BURST_DEF;
            capture_polarity_select_ff <= 1'b0;
            read_data_valid_flag_ff <= 1'b0;
            overflow_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if ((state_ff == `ST_IDLE) && read_start) begin
                words_ff <= {`BURST_W{1'b0}};
                target_ff <= (burst_words == {`BURST_W{1'b0}}) ? `BURST_DEF : burst_words;
                overflow_ff <= 1'b0;
            end
            // polarity chosen only at the first rise, then held
            if ((state_ff == `ST_WAIT_RISE) && rs_rise) begin
                capture_polarity_select_ff <= phase_ff;
            end
            if (push) begin
                words_ff <= words_ff + 1'b1;
                if (!fifo_in_ready) begin
                    overflow_ff <= 1'b1; // word lost, fifo not drained
                end
            end
            read_data_valid_flag_ff <= (nxt_state == `ST_DRAIN) && !fifo_empty;
        end
    end
    // ------------------------------------------------------------
    // per-cell capture and write output, strobes broadcast
    // ------------------------------------------------------------
    reg [DQ_W-1:0] q0_ff; // first word, rising capture
    reg [DQ_W-1:0] q1_pre_ff; // second word, rising capture
    reg [DQ_W-1:0] q1_ff; // second word, moved over on clocks where phase_ff is low
    wire [DQ_W-1:0] cap_word;
    genvar gi;
    generate
        for (gi = 0; gi < DQ_W; gi = gi + 1) begin : g_cell
            reg cap_ff; // capture register of this cell, holds the last strobed bit
            always @(posedge clk) begin
                if (srst) begin
                    cap_ff <= 1'b0;
                end else if (cap_edge || cap_any) begin
                    cap_ff <= dq_s2_ff[gi];
                end
            end
            assign cap_word[gi] = (cap_edge || cap_any) ? dq_s2_ff[gi] : cap_ff;
            // write path: strobe alternates q0 and q1 onto pad
            always @(posedge clk) begin
                if (srst) begin
                    q0_ff[gi] <= 1'b0;
                    q1_pre_ff[gi] <= 1'b0;
                    q1_ff[gi] <= 1'b0;
                    dq_out_ff[gi] <= 1'b0;
                end else begin
                    if (wr_load) begin
                        q0_ff[gi] <= wr_d0[gi];
                        q1_pre_ff[gi] <= wr_d1[gi];
                    end
                    if (!phase_ff) begin
                        q1_ff[gi] <= q1_pre_ff[gi];
                    end
                    dq_out_ff[gi] <= write_strobe_shifted_ff ? q0_ff[gi] : q1_ff[gi];
                end
            end
        end
    endgenerate
    // output enable only outside reads
    always @(posedge clk) begin
        if (srst) begin
            dq_oe_ff <= 1'b0;
        end else begin
            dq_oe_ff <= wr_load && (state_ff == `ST_IDLE);
        end
    end
    // ------------------------------------------------------------
    // read data fifo
    // ------------------------------------------------------------
    strobe_fifo #(
        .WIDTH(DQ_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .in_data(cap_word),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .out_data_ff(rd_data_ff),
        .out_valid_ff(rd_valid_ff),
        .out_ready(rd_ready),
        .empty(fifo_empty)
    );
endmodule // ddr_strobe_read_write_align

// ---- ddr_strobe_align_asserts.sv ----
// port checker for the strobe align block, bound after the module
// assumes one clk domain and a synchronous active-high srst
module ddr_strobe_align_asserts #(
    parameter DQ_W = 8
) (
    input wire clk,
    input wire srst,
    input wire read_start,
    input wire [5:0] pvt_code,
    input wire rd_ready,
    input wire read_strobe_shifted_ff,
    input wire capture_polarity_select_ff,
    input wire read_data_valid_flag_ff,
    input wire dll_locked_ff,
    input wire overflow_ff,
    input wire [DQ_W-1:0] rd_data_ff,
    input wire rd_valid_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // read side comes out of reset cleared
    property p_rst_clear;
        $fell(srst) |-> !rd_valid_ff && !read_data_valid_flag_ff && !overflow_ff;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("read side not clear");
    // a stalled word stands
    property p_hold;
        rd_valid_ff && !rd_ready |=> rd_valid_ff && $stable(rd_data_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled word moved");
    // burst flag never shows without data behind it
    property p_flag_data;
        read_data_valid_flag_ff |-> rd_valid_ff || $past(rd_valid_ff);
    endproperty
    a_flag_data: assert property (p_flag_data) else $error("flag without data");
    // polarity frozen while the burst drains
    property p_pol_hold;
        read_data_valid_flag_ff && $past(read_data_valid_flag_ff) |-> $stable(capture_polarity_select_ff);
    endproperty
    a_pol_hold: assert property (p_pol_hold) else $error("polarity moved in drain");
    // polarity only moves right after a delayed strobe rise
    property p_pol_rise;
        $changed(capture_polarity_select_ff) |-> $past(read_strobe_shifted_ff) && !$past(read_strobe_shifted_ff, 2);
    endproperty
    a_pol_rise: assert property (p_pol_rise) else $error("polarity moved off a strobe rise");
    // no word before preamble and strobe rise can pass
    property p_no_early;
        read_start |=> !rd_valid_ff [*3];
    endproperty
    a_no_early: assert property (p_no_early) else $error("word before strobe");
    // dll reaches a new code in bounded time
    property p_lock;
        $changed(pvt_code) |-> ##[1:80] dll_locked_ff;
    endproperty
    a_lock: assert property (p_lock) else $error("dll did not lock");
    // a moved target drops lock at once
    property p_unlock;
        $changed(pvt_code) |-> ##[1:2] !dll_locked_ff;
    endproperty
    a_unlock: assert property (p_unlock) else $error("lock kept on new code");
    // each read starts with a fresh overflow state
    property p_ovf_clr;
        read_start |-> ##[1:2] !overflow_ff;
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared");
endmodule // ddr_strobe_align_asserts

bind ddr_strobe_read_write_align ddr_strobe_align_asserts #(.DQ_W(DQ_W)) ddr_strobe_align_asserts_i (
    .clk(clk), .srst(srst), .read_start(read_start), .pvt_code(pvt_code), .rd_ready(rd_ready),
    .read_strobe_shifted_ff(read_strobe_shifted_ff),
    .capture_polarity_select_ff(capture_polarity_select_ff),
    .read_data_valid_flag_ff(read_data_valid_flag_ff), .dll_locked_ff(dll_locked_ff),
    .overflow_ff(overflow_ff), .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff));

// ---- ddr_mem_model.sv ----
// memory-side model: drives strobe and read data for one burst per go
// assumes count words, edge aligned data, 160 ns strobe period
module ddr_mem_model #(
    parameter DQ_W = 8
) (
    input wire logic go,
    input wire logic [7:0] count,
    input wire logic [7:0] seed,
    input wire logic slow,
    output logic dqs,
    output logic [DQ_W-1:0] dq,
    output logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    integer i;
    // strobe stands still outside bursts
    initial begin
        dqs = 1'b1; // termination holds the idle strobe high
        dq = '0;
        busy = 1'b0;
        forever begin
            @(posedge go);
            busy = 1'b1;
            dqs = 1'b0;
            dq = ~dq;
            #(slow ? 480 : 160);
            for (i = 0; i < count; i++) begin
                dqs = ~dqs;
                dq = DQ_W'(seed + i * 37);
                #80;
            end
            dqs = 1'b0;
            dq = ~dq;
            #80;
            dqs = 1'b1;
            busy = 1'b0;
        end
    end
endmodule // ddr_mem_model

// ---- tb.sv ----
// self-checking bench for the strobe align block
// assumes the memory model and the bound checker compile first
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DQ_W = 8;
    logic clk = 0, srst = 1, read_start = 0, wr_load = 0, rd_ready = 0, go = 0, slow = 0;
    logic [7:0] burst_words = 0, mcount = 0, mseed = 0;
    logic [5:0] pvt_code = 6'h02;
    logic [DQ_W-1:0] wr_d0 = 0, wr_d1 = 0, dq_out_ff, rd_data_ff, dq_pin;
    logic dqs_pin, mbusy, rss, wss, pol, dvf, lck, ovf, oe, rdv, wsp;
    logic ph = 0; // clock phase reference, cleared by reset, toggles each edge
    always @(posedge clk) ph <= srst ? 1'b0 : !ph;
    int bad_count = 0, n_compared = 0, t;
    logic [31:0] rng = 32'h00002C27;
    ddr_strobe_read_write_align #(.DQ_W(DQ_W)) ddr_strobe_read_write_align_i (
        .clk(clk), .srst(srst), .read_start(read_start), .burst_words(burst_words),
        .pvt_code(pvt_code), .dqs_pin(dqs_pin), .dq_pin(dq_pin), .wr_load(wr_load),
        .wr_d0(wr_d0), .wr_d1(wr_d1), .rd_ready(rd_ready), .read_strobe_shifted_ff(rss),
        .write_strobe_shifted_ff(wss), .capture_polarity_select_ff(pol),
        .read_data_valid_flag_ff(dvf), .dll_locked_ff(lck), .overflow_ff(ovf),
        .dq_out_ff(dq_out_ff), .dq_oe_ff(oe), .rd_data_ff(rd_data_ff), .rd_valid_ff(rdv));
    ddr_mem_model #(.DQ_W(DQ_W)) ddr_mem_model_i (.go(go), .count(mcount), .seed(mseed),
        .slow(slow), .dqs(dqs_pin), .dq(dq_pin), .busy(mbusy));
    initial forever #5 clk = ~clk;
    // xorshift source for all random stimulus
    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    // advance n edges, then drive just after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_lock();
        int k;
        for (k = 0; k < 200 && lck !== 1'b1; k++) step(1);
        chk(lck, 1, "dll lock");
        if (lck !== 1'b1) summarize();
    endtask
    // one read burst against a queue model of the words sent
    task automatic rd_burst(input logic [7:0] bw, input logic ovf_exp);
        int n, k, got;
        logic [DQ_W-1:0] q[$];
        int phs;
        logic pol_exp;
        n = (bw == 8'h00) ? 8 : int'(bw);
        mseed = 8'(xs());
        for (k = 0; k < n; k++) q.push_back(DQ_W'(mseed + k * 37));
        mcount = 8'(n);
        slow = 1'(xs());
        burst_words = bw;
        read_start = 1;
        go = 1;
        step(1);
        read_start = 0;
        go = 0;
        phs = 0;
        for (k = 0; k < 3000 && (mbusy || k < 2); k++) begin
            if (phs == 0 && !rss) phs = 1;
            else if (phs == 1 && rss) begin
                phs = 2;
                pol_exp = ph; // phase in the cycle of the first delayed rise
            end
            step(1);
        end
        if (mbusy) begin
            chk(0, 1, "memory model hang");
            summarize();
        end
        step(100);
        if (!ovf_exp) chk(dvf, 1, "flag after burst");
        chk(ovf, ovf_exp, "overflow");
        chk(pol, pol_exp, "polarity at first rise");
        got = 0;
        for (k = 0; k < 300; k++) begin
            rd_ready = 1'(xs());
            if (rd_ready && rdv) begin
                chk(rd_data_ff, q.pop_front(), "read word");
                got++;
            end
            step(1);
        end
        rd_ready = 0;
        chk(dvf, 0, "flag after drain");
        chk(ovf_exp ? (got >= 8 && got < n) : got == n, 1, "word count");
        $display("burst of %0d words done", n);
    endtask
    initial begin
        step(6);
        srst = 0;
        wait_lock();
        for (t = 0; t < 5; t++) begin
            pvt_code = 6'(1 + xs() % 4);
            step(3);
            wait_lock();
            rd_burst(t == 0 ? 8'h00 : 8'(1 + xs() % 8), 0);
        end
        rd_burst(8'h0A, 1);
        mcount = 8'h10;
        go = 1; // strobe toggles with no read taken, so the pad mux sees both levels
        step(1);
        go = 0;
        step(20);
        repeat (6) begin
            wr_d0 = DQ_W'(xs());
            wr_d1 = DQ_W'(xs());
            wr_load = 1;
            step(3);
            wsp = wss; // strobe level that selects the pad word at the next edge
            step(1);
            chk(oe, 1, "pad enable");
            chk(dq_out_ff, wsp ? wr_d0 : wr_d1, "pad data");
            wr_load = 0;
            step(1 + xs() % 8);
        end
        for (t = 0; t < 3000 && mbusy; t++) step(1);
        if (mbusy) begin
            chk(0, 1, "memory model hang");
            summarize();
        end
        step(20);
        chk(rss, dqs_pin, "read strobe at rest");
        $display("write test done");
        summarize();
    end
endmodule // tb
